// [logic/phpif_map.svh]
// Offsets, field positions, reset values and timing counts of the parallel host port
`ifndef PHPIF_MAP_SVH
`define PHPIF_MAP_SVH

// Register offsets
`define PHPIF_SYSCFG_ADDR 8'h10
`define PHPIF_IEN_ADDR 8'hf0
`define PHPIF_IFLAG_ADDR 8'hf1

// Field positions
`define PHPIF_SYSCFG_WIDTH_LSB 0
`define PHPIF_WIDTH_16 2'h3
`define PHPIF_FLAG_KEY 4
`define PHPIF_FLAG_DMA 3
`define PHPIF_FLAG_TOUCH 2
`define PHPIF_FLAG_BTE 1
`define PHPIF_FLAG_HOST 0
`define PHPIF_STAT_OVR 7
`define PHPIF_STAT_IRQ 6
`define PHPIF_STAT_WIDE 0

// Reset values
`define PHPIF_SYSCFG_RST 8'h00
`define PHPIF_IEN_RST 5'h00
`define PHPIF_IFLAG_RST 5'h00

// Host-relative block transfer operation codes
`define PHPIF_OP_WR_ROP 4'h0
`define PHPIF_OP_RD 4'h1
`define PHPIF_OP_TR_WR 4'h4
`define PHPIF_OP_CEXP 4'h8
`define PHPIF_OP_CEXP_TR 4'h9

// Timing
`define PHPIF_CLK_NS 40
`define PHPIF_GAP_NS 200
`define PHPIF_GAP_CYC ((`PHPIF_GAP_NS + `PHPIF_CLK_NS - 1) / `PHPIF_CLK_NS)

`endif

// [logic/phpif_pkg.sv]
// Types shared by the parallel host port
`default_nettype none
package phpif_pkg;

    // Host bus pins, sampled on the system clock
    typedef struct packed {
        logic cs_n;
        logic rs;
        logic wr_n_rw;
        logic rd_n_en;
        logic [15:0] data;
    } phpif_pins_t;

    // Event pulses from the interrupt sources
    typedef struct packed {
        logic key;
        logic dma;
        logic touch;
        logic bte_done;
        logic bte_host;
        logic font_done;
    } phpif_events_t;

    // Access cycle sequencer
    typedef enum logic [1:0] {
        PHPIF_IDLE = 2'b00,
        PHPIF_ACCESS = 2'b01,
        PHPIF_RECOVER = 2'b11
    } phpif_state_t;

endpackage
`default_nettype wire

// [logic/phpif_top.sv]
// Parallel host port with interrupt flag and enable registers
`default_nettype none
`include "phpif_map.svh"

module phpif_top
    import phpif_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic bus_style_strap_i,
    input wire phpif_pins_t pins_i,
    input wire phpif_events_t events_i,
    input wire logic bte_enable_i,
    input wire logic [3:0] bte_op_i,
    input wire logic text_mode_i,
    output logic [15:0] data_o,
    output logic [1:0] data_oe_o,
    output logic irq_n_o,
    output logic wait_n_o,
    output logic bus_wide_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Operations whose data moves through the host bus
    function automatic logic phpif_host_rel(input logic [3:0] op);
        logic hit;
        hit = 1'b0;
        unique case (op)
            `PHPIF_OP_WR_ROP,
            `PHPIF_OP_RD,
            `PHPIF_OP_TR_WR,
            `PHPIF_OP_CEXP,
            `PHPIF_OP_CEXP_TR: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Width field value to wide flag
    function automatic logic phpif_is_wide(input logic [7:0] cfg);
        return cfg[`PHPIF_SYSCFG_WIDTH_LSB +: 2] == `PHPIF_WIDTH_16;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    localparam logic [2:0] GAP_CYC = 3'(`PHPIF_GAP_CYC);

    phpif_state_t state_reg, state_next;
    logic strap_reg, strap_next;
    logic cyc_wr_reg, cyc_wr_next;
    logic cyc_rs_reg, cyc_rs_next;
    logic cyc_wide_reg, cyc_wide_next;
    logic [7:0] addr_reg, addr_next;
    logic [7:0] syscfg_reg, syscfg_next;
    logic [4:0] ien_reg, ien_next;
    logic [4:0] flag_reg, flag_next;
    logic [15:0] wdata_reg, wdata_next;
    logic [2:0] gap_reg, gap_next;
    logic [15:0] data_o_reg, data_o_next;
    logic [1:0] oe_reg, oe_next;
    logic irq_n_reg, irq_n_next;
    logic ovr_reg, ovr_next;

    logic act;
    logic is_wr;
    logic [4:0] flag_set;
    logic [4:0] flag_clr;
    logic [4:0] flag_upd;
    logic src0;
    logic [7:0] rd_val;
    logic [7:0] status_val;
    logic end_wr;
    logic end_rd;

    ////////////////////////////////////////////////////////////////////////////
    // Strobe decode

    // Split strobes or enable strobe with direction line
    // Style comes from the latched strap, so a pin glitch after reset
    // cannot flip the decode in the middle of an access
    always_comb begin
        if (!strap_reg) begin
            act = !pins_i.cs_n && (!pins_i.wr_n_rw || !pins_i.rd_n_en);
            is_wr = !pins_i.wr_n_rw;
        end else begin
            act = !pins_i.cs_n && pins_i.rd_n_en;
            is_wr = !pins_i.wr_n_rw;
        end
    end

    // Access end events
    assign end_wr = (state_reg == PHPIF_ACCESS) && !act && cyc_wr_reg;
    assign end_rd = (state_reg == PHPIF_ACCESS) && !act && !cyc_wr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read values

    // Status word for a register-select read
    always_comb begin
        status_val = 8'h00;
        status_val[`PHPIF_STAT_OVR] = ovr_reg;
        status_val[`PHPIF_STAT_IRQ] = !irq_n_reg;
        status_val[`PHPIF_STAT_WIDE] = phpif_is_wide(syscfg_reg);
    end

    // Register read multiplexer, unmapped reads zero
    always_comb begin
        rd_val = 8'h00;
        unique case (addr_reg)
            `PHPIF_SYSCFG_ADDR: rd_val = syscfg_reg;
            `PHPIF_IEN_ADDR: rd_val = {3'h0, ien_reg};
            `PHPIF_IFLAG_ADDR: rd_val = {3'h0, flag_reg};
            default: rd_val = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt flags

    // Source of flag 0 depends on engine and text mode
    always_comb begin
        src0 = 1'b0;
        if (bte_enable_i && phpif_host_rel(bte_op_i)) begin
            src0 = events_i.bte_host;
        end else if (!bte_enable_i && text_mode_i) begin
            src0 = events_i.font_done;
        end
    end

    // Set vector from the sources
    always_comb begin
        flag_set = 5'h00;
        flag_set[`PHPIF_FLAG_KEY] = events_i.key;
        flag_set[`PHPIF_FLAG_DMA] = events_i.dma;
        flag_set[`PHPIF_FLAG_TOUCH] = events_i.touch;
        flag_set[`PHPIF_FLAG_BTE] = events_i.bte_done;
        flag_set[`PHPIF_FLAG_HOST] = src0;
    end

    // Write one clears, write zero leaves the flag
    always_comb begin
        flag_clr = 5'h00;
        if (end_wr && !cyc_rs_reg && addr_reg == `PHPIF_IFLAG_ADDR) begin
            flag_clr = wdata_reg[4:0];
        end
    end

    // Per-flag update, a hardware set wins over a host clear in one cycle
    // so that an event landing on the clear write is never lost
    for (genvar i = 0; i < 5; i++) begin : g_flag
        assign flag_upd[i] = flag_set[i] | (flag_reg[i] & !flag_clr[i]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // Writes land only when the strobe ends, using the data seen on the
    // last strobe cycle; reads refresh the output while the strobe stays
    // Sequencer, register file and output data
    always_comb begin
        state_next = state_reg;
        strap_next = strap_reg;
        cyc_wr_next = cyc_wr_reg;
        cyc_rs_next = cyc_rs_reg;
        cyc_wide_next = cyc_wide_reg;
        addr_next = addr_reg;
        syscfg_next = syscfg_reg;
        ien_next = ien_reg;
        wdata_next = wdata_reg;
        gap_next = gap_reg;
        data_o_next = data_o_reg;
        oe_next = oe_reg;
        ovr_next = ovr_reg;
        // Set wins over clear
        flag_next = flag_upd;
        unique case (state_reg)
            PHPIF_IDLE: begin
                if (act) begin
                    state_next = PHPIF_ACCESS;
                    cyc_wr_next = is_wr;
                    cyc_rs_next = pins_i.rs;
                    cyc_wide_next = phpif_is_wide(syscfg_reg);
                    wdata_next = pins_i.data;
                end
            end
            PHPIF_ACCESS: begin
                if (act) begin
                    if (cyc_wr_reg) begin
                        wdata_next = pins_i.data;
                    end else begin
                        // Narrow width drives only the low byte
                        data_o_next = {8'h00, cyc_rs_reg ? status_val : rd_val};
                        oe_next = cyc_wide_reg ? 2'b11 : 2'b01;
                    end
                end else begin
                    state_next = PHPIF_RECOVER;
                    gap_next = GAP_CYC;
                    oe_next = 2'b00;
                    data_o_next = 16'h0000;
                    if (cyc_wr_reg && cyc_rs_reg) begin
                        addr_next = wdata_reg[7:0];
                    end else if (cyc_wr_reg) begin
                        unique case (addr_reg)
                            `PHPIF_SYSCFG_ADDR: syscfg_next = wdata_reg[7:0];
                            `PHPIF_IEN_ADDR: ien_next = wdata_reg[4:0];
                            default: syscfg_next = syscfg_reg;
                        endcase
                    end
                    if (end_rd && cyc_rs_reg) begin
                        ovr_next = 1'b0;
                    end
                end
            end
            PHPIF_RECOVER: begin
                // A cycle started too soon is dropped and noted
                // The recovery stretches while the strobe stays up, so a
                // dropped cycle never turns into a half-taken one
                if (act) begin
                    ovr_next = 1'b1;
                end
                if (gap_reg <= 3'h1) begin
                    state_next = act ? PHPIF_RECOVER : PHPIF_IDLE;
                    gap_next = 3'h0;
                end else begin
                    gap_next = gap_reg - 3'h1;
                end
            end
            default: begin
                state_next = PHPIF_IDLE;
            end
        endcase
        irq_n_next = !(|(flag_next & ien_next));
        if (reset_i) begin
            // Strap is caught while reset is held
            strap_next = bus_style_strap_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Strap follows its pin during reset only
    always_ff @(posedge mclk_i) begin
        strap_reg <= strap_next;
    end

    // Control and data state
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_reg <= PHPIF_IDLE;
            cyc_wr_reg <= 1'b0;
            cyc_rs_reg <= 1'b0;
            cyc_wide_reg <= 1'b0;
            addr_reg <= 8'h00;
            syscfg_reg <= `PHPIF_SYSCFG_RST;
            ien_reg <= `PHPIF_IEN_RST;
            flag_reg <= `PHPIF_IFLAG_RST;
            wdata_reg <= 16'h0000;
            gap_reg <= 3'h0;
            data_o_reg <= 16'h0000;
            oe_reg <= 2'b00;
            irq_n_reg <= 1'b1;
            ovr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cyc_wr_reg <= cyc_wr_next;
            cyc_rs_reg <= cyc_rs_next;
            cyc_wide_reg <= cyc_wide_next;
            addr_reg <= addr_next;
            syscfg_reg <= syscfg_next;
            ien_reg <= ien_next;
            flag_reg <= flag_next;
            wdata_reg <= wdata_next;
            gap_reg <= gap_next;
            data_o_reg <= data_o_next;
            oe_reg <= oe_next;
            irq_n_reg <= irq_n_next;
            ovr_reg <= ovr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Busy while a cycle or its recovery runs, active low
    // Host may poll this instead of counting the recovery gap itself
    // Lane enables drop at strobe end so the host never sees bus contention
    assign wait_n_o = (state_reg == PHPIF_IDLE);
    assign irq_n_o = irq_n_reg;
    assign data_o = data_o_reg;
    assign data_oe_o = oe_reg;
    assign bus_wide_o = phpif_is_wide(syscfg_reg);

endmodule // phpif_top
`default_nettype wire

// [verification/phpif_checker.sv]
// Assertion checker for the parallel host port
`default_nettype none
module phpif_checker
    import phpif_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic bus_style_strap_i,
    input wire phpif_pins_t pins_i,
    input wire phpif_events_t events_i,
    input wire logic bte_enable_i,
    input wire logic [3:0] bte_op_i,
    input wire logic text_mode_i,
    input wire logic [15:0] data_o,
    input wire logic [1:0] data_oe_o,
    input wire logic irq_n_o,
    input wire logic wait_n_o,
    input wire logic bus_wide_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    logic act;
    // Strobe decode for either bus style
    assign act = !pins_i.cs_n && (bus_style_strap_i ? pins_i.rd_n_en
        : (!pins_i.wr_n_rw || !pins_i.rd_n_en));
    a_reset_quiet: assert property ($fell(reset_i) |-> irq_n_o && wait_n_o
        && !bus_wide_o && data_oe_o == 2'b00) else $error("outputs busy after reset");
    a_upper_zero: assert property (data_o[15:8] == 8'h00)
        else $error("upper read byte not zero");
    a_lane_width: assert property (data_oe_o != 2'b00 |-> data_oe_o == {bus_wide_o, 1'b1})
        else $error("lane enables disagree with width");
    a_take_busy: assert property (wait_n_o && act |=> !wait_n_o)
        else $error("strobe not taken");
    a_gap_ends: assert property ($fell(act) && !wait_n_o |-> ##[1:8] wait_n_o)
        else $error("recovery never ends");
    a_read_drive: assert property (wait_n_o && act && pins_i.wr_n_rw ##1 act [*3]
        |-> data_oe_o != 2'b00) else $error("read data not driven");
    a_wide_write: assert property ($changed(bus_wide_o) |-> $past(act, 2)
        && !$past(pins_i.wr_n_rw, 2)) else $error("width changed without write");
    a_irq_cause: assert property ($fell(irq_n_o) |-> $past(|events_i) || $past(act, 2))
        else $error("interrupt without cause");
    a_irq_clear: assert property ($rose(irq_n_o) |-> $past(act, 2))
        else $error("interrupt dropped without write");
    c_wide_read: cover property (data_oe_o == 2'b11);
    c_irq: cover property ($fell(irq_n_o));
    c_style_e: cover property (bus_style_strap_i && $fell(act));
endmodule // phpif_checker

bind phpif_top phpif_checker u_chk (.mclk_i, .reset_i, .bus_style_strap_i, .pins_i,
    .events_i, .bte_enable_i, .bte_op_i, .text_mode_i, .data_o, .data_oe_o, .irq_n_o,
    .wait_n_o, .bus_wide_o);
`default_nettype wire

// [verification/phpif_host_model.sv]
// Host microcontroller model driving the parallel strobes
`default_nettype none
module phpif_host_model
    import phpif_pkg::*;
(
    input wire logic mclk_i,
    input wire logic strap_i,
    input wire logic [15:0] data_i,
    input wire logic [1:0] data_oe_i,
    output var phpif_pins_t pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle strobes; released lines show the inverse of their last value
    task automatic park();
        pins_o.cs_n = 1'b1;
        pins_o.wr_n_rw = 1'b1;
        pins_o.rd_n_en = !strap_i;
        pins_o.rs = !pins_o.rs;
        pins_o.data = ~pins_o.data;
    endtask
    // One access: strobe held four clocks, then the gap
    task automatic cycle(input logic rs, input logic wr, input logic [15:0] d,
                         output logic [15:0] q, output logic [1:0] oe,
                         input int gap = 7);
        @(negedge mclk_i);
        pins_o.cs_n = 1'b0;
        pins_o.rs = rs;
        pins_o.data = d;
        pins_o.wr_n_rw = !wr;
        pins_o.rd_n_en = strap_i | wr;
        repeat (4) @(negedge mclk_i);
        q = data_i;
        oe = data_oe_i;
        park();
        repeat (gap) @(negedge mclk_i); // Over five clocks apart at the default gap of 7
    endtask
    // Short write strobe inside the recovery time, to be dropped
    task automatic early();
        @(negedge mclk_i);
        pins_o.cs_n = 1'b0;
        pins_o.wr_n_rw = 1'b0;
        pins_o.rd_n_en = 1'b1;
        @(negedge mclk_i);
        park();
        repeat (7) @(negedge mclk_i); // Gap restored after the breach
    endtask
    initial pins_o = '{1'b1, 1'b0, 1'b1, 1'b1, 16'h0000};
endmodule // phpif_host_model
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the parallel host port
`default_nettype none
`include "phpif_map.svh"
module tb
    import phpif_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i, reset_i, strap, bte_en, text_en, irq_n, wait_n, wide;
    logic [3:0] op;
    phpif_pins_t pins;
    phpif_events_t ev;
    logic [15:0] dout, q;
    logic [1:0] oe, qoe;
    logic [7:0] rnd = 8'h2a;
    int num_errors = 0;
    int n_compared = 0;
    int en_m, fl_m, cfg_m;
    int ops[$] = '{`PHPIF_OP_WR_ROP, `PHPIF_OP_RD, `PHPIF_OP_TR_WR, `PHPIF_OP_CEXP,
        `PHPIF_OP_CEXP_TR};
    phpif_top DUT (.mclk_i, .reset_i, .bus_style_strap_i(strap), .pins_i(pins), .events_i(ev),
        .bte_enable_i(bte_en), .bte_op_i(op), .text_mode_i(text_en), .data_o(dout),
        .data_oe_o(oe), .irq_n_o(irq_n), .wait_n_o(wait_n), .bus_wide_o(wide));
    phpif_host_model host (.mclk_i, .strap_i(strap), .data_i(dout), .data_oe_i(oe),
        .pins_o(pins));
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d, compares %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Address by command write, then one data cycle
    task automatic access(input logic [7:0] a, input logic wr, input logic [7:0] d);
        host.cycle(1'b1, 1'b1, {8'h00, a}, q, qoe);
        host.cycle(1'b0, wr, {rnd, d}, q, qoe);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        access(a, 1'b1, d);
        if (a == `PHPIF_IEN_ADDR) en_m = d & 8'h1f;
        if (a == `PHPIF_IFLAG_ADDR) fl_m &= ~d;
        if (a == `PHPIF_SYSCFG_ADDR) cfg_m = d;
    endtask
    task automatic reg_rd(input logic [7:0] a);
        int e;
        e = a == `PHPIF_IEN_ADDR ? en_m : a == `PHPIF_IFLAG_ADDR ? fl_m
            : a == `PHPIF_SYSCFG_ADDR ? cfg_m : 0;
        access(a, 1'b0, 8'h00);
        check(q, 16'(e));
        check(qoe, cfg_m[1:0] == 2'b11 ? 2'b11 : 2'b01);
    endtask
    // One event pulse, model flag update, then interrupt level
    task automatic pulse(input int b);
        logic hit;
        hit = 1'b0;
        foreach (ops[k]) if (ops[k] == op) hit = 1'b1;
        @(negedge mclk_i);
        ev = 6'(1 << b);
        @(negedge mclk_i);
        ev = 6'h00;
        if (b > 1) fl_m |= 1 << (b - 1);
        if (b == 1 && bte_en && hit) fl_m |= 1;
        if (b == 0 && !bte_en && text_en) fl_m |= 1;
        check(irq_n, !(|(fl_m & en_m)));
    endtask
    initial begin
        {reset_i, bte_en, text_en, op, ev} = '0;
        for (int s = 0; s < 2; s++) begin
            reset_i = 1'b1;
            strap = s[0];
            host.park();
            repeat (10) @(negedge mclk_i);
            reset_i = 1'b0;
            {en_m, fl_m, cfg_m} = '0;
            @(negedge mclk_i);
            check(wait_n, 1'b1);
            check(irq_n, 1'b1);
            reg_rd(`PHPIF_IFLAG_ADDR);
            reg_rd(`PHPIF_IEN_ADDR);
            reg_wr(`PHPIF_SYSCFG_ADDR, 8'h03);
            check(wide, 1'b1);
            reg_rd(`PHPIF_SYSCFG_ADDR);
            reg_wr(`PHPIF_SYSCFG_ADDR, 8'h00);
            reg_rd(8'h55);
            rnd = lfsr(rnd);
            reg_wr(`PHPIF_IEN_ADDR, rnd);
            for (int b = 5; b > 1; b--) pulse(b);
            host.cycle(1'b0, 1'b0, 16'h0000, q, qoe, 1);
            host.early();
            host.cycle(1'b1, 1'b0, 16'h0000, q, qoe);
            check(q, {8'h00, 1'b1, |(fl_m & en_m), 6'h00});
            host.cycle(1'b1, 1'b0, 16'h0000, q, qoe);
            check(q, {9'h000, |(fl_m & en_m), 6'h00});
            rnd = lfsr(rnd);
            reg_wr(`PHPIF_IFLAG_ADDR, rnd);
            reg_rd(`PHPIF_IFLAG_ADDR);
            bte_en = 1'b1;
            op = 4'h2;
            pulse(1);
            foreach (ops[k]) begin
                op = ops[k][3:0];
                pulse(1);
                reg_rd(`PHPIF_IFLAG_ADDR);
                reg_wr(`PHPIF_IFLAG_ADDR, 8'h01);
            end
            bte_en = 1'b0;
            text_en = 1'b1;
            pulse(0);
            reg_rd(`PHPIF_IFLAG_ADDR);
            reg_wr(`PHPIF_IFLAG_ADDR, 8'h1f);
            text_en = 1'b0;
            pulse(0);
            reg_rd(`PHPIF_IFLAG_ADDR);
        end
        end_of_test();
    end
    // Cap on run length
    initial begin
        repeat (100000) @(posedge mclk_i);
        num_errors++;
        end_of_test();
    end
endmodule // tb
`default_nettype wire
